//--- rtl/btcs_decode.sv
`timescale 1ns/1ps
`include "btcs_consts.svh"
module btcs_decode (
  btcs_dec_if.dec dif
);
  import btcs_pkg::*;
  logic ok_hdr;
  logic ok_bit;
  logic ok_form;
  assign dif.form =
    btcs_form_t'(dif.opcode[15:14]);
  assign dif.field6 = dif.opcode[13:8];
  assign dif.ea_mode = dif.opcode[13:11];
  assign dif.ea_reg = dif.opcode[10:8];
  assign dif.space = dif.opcode[`BTCS_F_SPACE];
  assign dif.set_op = dif.opcode[`BTCS_F_SETSEL];
  assign dif.bit_idx = dif.opcode[4:0];
  assign dif.needs_ext = (dif.form == FORM_EA) &&
    (dif.opcode[13:8] == `BTCS_ABS_EA);
  assign ok_hdr = (dif.opcode[23:16] == `BTCS_UPPER_BYTE) &&
    !dif.opcode[`BTCS_F_ZERO7];
  assign ok_bit = (dif.opcode[4:0] <= `BTCS_BIT_MAX);
  always_comb begin
    case (dif.form)
      FORM_REG: ok_form = dif.opcode[`BTCS_F_SPACE] &&
        reg_code_ok(dif.opcode[13:8]);
      FORM_EA: ok_form = (dif.opcode[13:11] != 3'h6) ||
        (dif.opcode[13:8] == `BTCS_ABS_EA);
      default: ok_form = 1'b1;
    endcase
  end
  assign dif.legal = ok_hdr && ok_bit && ok_form;
endmodule // btcs_decode

//--- rtl/btcs_exec.sv
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "btcs_consts.svh"
// Behaviour
// - Set op: carry gets bit, bit forced one
// - Clear op: carry gets bit, bit forced zero
// - Carry updated before destination is written
// - Bit index in opcode bits 4 to 0
// - Only indices 0 to 23 accepted
// - Memory read and write locked together
// - Effective address form: bits 15:14 = 01
// - Effective address mode field decoding
// - Absolute short form: bits 15:14 = 00
// - I/O short form: bits 15:14 = 10
// - Register form 11, common header, bit 5 selects
// - Destination register code groups
// - Four cycles plus memory access cycles; the code counts memory cycles inside a four-cycle minimum
// - One word, plus extension when needed
// - All memory alterable modes accepted
// - Status word flags change only when selected
// - Status word mode bits change only when selected
// - Carry mirrors tested bit for other destinations
// - Other flags untouched for other destinations
module btcs_exec #(
  parameter int MEM_AW = 16
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic MEM_SPACE,
  output logic MEM_LOCK,
  output logic [MEM_AW-1:0] MEM_ADDR,
  output logic [23:0] MEM_WDATA,
  input wire logic [23:0] MEM_RDATA,
  input wire logic MEM_ACK,
  output logic BUSY,
  output logic CARRY
);
  import btcs_pkg::*;

  if (MEM_AW < 7 || MEM_AW > 24) begin : g_bad_aw
    $error("MEM_AW must be 7..24");
  end

  btcs_dec_if dif();
  btcs_decode u_dec (
    .dif(dif.dec)
  );

  btcs_state_t state;
  logic [23:0] op_q;
  logic [MEM_AW-1:0] ext_q;
  logic [5:0] regsel;
  logic [15:0] psw;
  logic [2:0] cyc;
  logic illegal;
  logic done;
  logic extw;
  logic [23:0] rf [0:63];
  logic req;
  logic bus_wr;
  logic bus_rd;
  logic start;
  logic idle;
  logic is_psw;
  logic [23:0] cur;
  logic [23:0] next_reg;
  logic [23:0] next_mem;
  logic [31:0] next_rdata;
  logic [MEM_AW-1:0] rn;
  logic [MEM_AW-1:0] nn;
  logic [MEM_AW-1:0] next_addr;
  logic [MEM_AW-1:0] next_rn;
  logic rn_upd;
  logic [15:0] sel_mask;
  logic [2:0] hcnt;

  assign dif.opcode = op_q;
  assign idle = (state == ST_IDLE);
  assign req = AVS_READ | AVS_WRITE;
  // Writes taken on the edge where waitrequest is seen low; read data latched while it is still high
  assign bus_wr = CLK_EN && AVS_WRITE && !AVS_WAITREQUEST;
  assign bus_rd = CLK_EN && AVS_READ && AVS_WAITREQUEST;
  assign start = bus_wr && idle && (AVS_ADDRESS == `BTCS_OFF_OPCODE);
  assign is_psw = (dif.field6 == `BTCS_PSW_CODE);
  assign CARRY = psw[0];
  assign sel_mask = 16'(32'h1 << dif.bit_idx);

  // Waitrequest drops for one cycle per request: fixed latency
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if (CLK_EN) begin
      AVS_WAITREQUEST <= !(req && AVS_WAITREQUEST);
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    case (AVS_ADDRESS)
      `BTCS_OFF_OPCODE: next_rdata = {8'h00, op_q};
      `BTCS_OFF_EXT: next_rdata = 32'(ext_q);
      `BTCS_OFF_STATUS: begin
        next_rdata[`BTCS_ST_BUSY] = BUSY;
        next_rdata[`BTCS_ST_ILL] = illegal;
        next_rdata[`BTCS_ST_CARRY] = psw[0];
        next_rdata[`BTCS_ST_EXTW] = extw;
        next_rdata[`BTCS_ST_DONE] = done;
      end
      `BTCS_OFF_PSW: next_rdata = {16'h0000, psw};
      `BTCS_OFF_REGSEL: next_rdata = {26'h0000000, regsel};
      `BTCS_OFF_REGDAT: next_rdata = (regsel == `BTCS_PSW_CODE) ?
        {16'h0000, psw} : {8'h00, rf[regsel]};
      default: next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      AVS_READDATA <= 32'h00000000;
    end else if (bus_rd) begin
      AVS_READDATA <= next_rdata;
    end
  end

  // Software setup registers; ignored while an instruction runs
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      op_q <= 24'h000000;
      ext_q <= '0;
      regsel <= 6'h00;
    end else if (bus_wr && idle) begin
      if (AVS_ADDRESS == `BTCS_OFF_OPCODE) begin
        op_q <= be_merge(op_q, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
      if (AVS_ADDRESS == `BTCS_OFF_EXT) begin
        ext_q <= MEM_AW'(be_merge(24'(ext_q), AVS_WRITEDATA,
          AVS_BYTEENABLE));
      end
      if (AVS_ADDRESS == `BTCS_OFF_REGSEL && AVS_BYTEENABLE[0]) begin
        regsel <= AVS_WRITEDATA[5:0];
      end
    end
  end

  // Address unit: pointer and offset live in the register file
  always_comb begin
    rn = MEM_AW'(rf[{3'h2, dif.ea_reg}]);
    nn = MEM_AW'(rf[{3'h3, dif.ea_reg}]);
    next_rn = rn;
    rn_upd = 1'b0;
    next_addr = rn;
    case (dif.form)
      FORM_ABS: next_addr = {{(MEM_AW-6){1'b0}}, dif.field6};
      FORM_IO: next_addr = {{(MEM_AW-6){1'b1}}, dif.field6};
      FORM_EA: begin
        rn_upd = 1'b1;
        case (dif.ea_mode)
          3'h0: next_rn = rn - nn;
          3'h1: next_rn = rn + nn;
          3'h2: next_rn = rn - 1'b1;
          3'h3: next_rn = rn + 1'b1;
          3'h5: begin
            next_addr = rn + nn;
            rn_upd = 1'b0;
          end
          3'h6: begin
            next_addr = ext_q;
            rn_upd = 1'b0;
          end
          3'h7: begin
            next_rn = rn - 1'b1;
            next_addr = rn - 1'b1;
          end
          default: rn_upd = 1'b0;
        endcase
      end
      default: next_addr = rn;
    endcase
  end

  // Modifier registers are kept but linear addressing only
  always_comb begin
    cur = is_psw ? {8'h00, psw} : rf[dif.field6];
    next_reg = bit_apply(cur, dif.bit_idx, dif.set_op);
    next_mem = bit_apply(MEM_RDATA, dif.bit_idx, dif.set_op);
  end

  always_ff @(posedge MCLK) begin
    if (CLK_EN) begin
      if (state == ST_ADDR && dif.legal && rn_upd) begin
        rf[{3'h2, dif.ea_reg}] <= 24'(next_rn);
      end else if (state == ST_REG && !is_psw) begin
        rf[dif.field6] <= next_reg;
      end else if (bus_wr && idle && AVS_ADDRESS == `BTCS_OFF_REGDAT &&
          regsel != `BTCS_PSW_CODE) begin
        rf[regsel] <= be_merge(rf[regsel], AVS_WRITEDATA, AVS_BYTEENABLE);
      end
    end
  end

  // Status word: reserved bits always read zero
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      psw <= `BTCS_PSW_RST;
    end else if (CLK_EN) begin
      if (state == ST_REG && is_psw) begin
        psw <= next_reg[15:0] & `BTCS_PSW_MASK;
      end else if (state == ST_REG) begin
        psw[0] <= cur[dif.bit_idx];
      end else if (state == ST_RD && MEM_ACK) begin
        psw[0] <= MEM_RDATA[dif.bit_idx];
      end else if (bus_wr && idle && (AVS_ADDRESS == `BTCS_OFF_PSW ||
          (AVS_ADDRESS == `BTCS_OFF_REGDAT &&
          regsel == `BTCS_PSW_CODE))) begin
        psw <= 16'(be_merge({8'h00, psw}, AVS_WRITEDATA,
          AVS_BYTEENABLE)) & `BTCS_PSW_MASK;
      end
    end
  end

  // Sequencer; cyc counts cycles since the opcode was taken
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= ST_IDLE;
      cyc <= 3'h0;
      BUSY <= 1'b0;
      illegal <= 1'b0;
      done <= 1'b0;
      extw <= 1'b0;
    end else if (CLK_EN) begin
      if (!idle && cyc != 3'h7) cyc <= cyc + 3'h1;
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_ADDR;
            cyc <= 3'h0;
            BUSY <= 1'b1;
            illegal <= 1'b0;
            done <= 1'b0;
          end
        end
        ST_ADDR: begin
          extw <= dif.needs_ext;
          if (!dif.legal) begin
            state <= ST_IDLE;
            BUSY <= 1'b0;
            illegal <= 1'b1;
          end else if (dif.form == FORM_REG) begin
            state <= ST_REG;
          end else begin
            state <= ST_RD;
          end
        end
        ST_RD: if (MEM_ACK) state <= ST_WR;
        ST_WR: if (MEM_ACK) state <= ST_PAD;
        ST_REG: state <= ST_PAD;
        ST_PAD: begin
          if (cyc >= `BTCS_BASE_CYC - 3'h1) begin
            state <= ST_IDLE;
            BUSY <= 1'b0;
            done <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Lock spans read and write so no master can slip in between
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      MEM_REQ <= 1'b0;
      MEM_WE <= 1'b0;
      MEM_LOCK <= 1'b0;
      MEM_SPACE <= 1'b0;
      MEM_ADDR <= '0;
      MEM_WDATA <= 24'h000000;
    end else if (CLK_EN) begin
      if (state == ST_ADDR && dif.legal && dif.form != FORM_REG) begin
        MEM_REQ <= 1'b1;
        MEM_WE <= 1'b0;
        MEM_LOCK <= 1'b1;
        MEM_SPACE <= dif.space;
        MEM_ADDR <= next_addr;
      end else if (state == ST_RD && MEM_ACK) begin
        MEM_WE <= 1'b1;
        MEM_WDATA <= next_mem;
      end else if (state == ST_WR && MEM_ACK) begin
        MEM_REQ <= 1'b0;
        MEM_WE <= 1'b0;
        MEM_LOCK <= 1'b0;
      end
    end
  end

  // Helper: busy edges of the current instruction
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      hcnt <= 3'h0;
    end else if (CLK_EN) begin
      if (start) hcnt <= 3'h0;
      else if (BUSY && hcnt != 3'h7) hcnt <= hcnt + 3'h1;
    end
  end

  a_lock_over_rmw: assert property (@(posedge MCLK)
    disable iff (!RST_B)
    (state == ST_RD || state == ST_WR) |-> MEM_LOCK && MEM_REQ)
    else $error("lock or request dropped inside read-modify-write");
  a_lock_to_write: assert property (@(posedge MCLK)
    disable iff (!RST_B)
    (MEM_LOCK && !MEM_WE && MEM_ACK && CLK_EN) |=> MEM_LOCK && MEM_WE)
    else $error("lock released between read and write");
  a_set_writes_one: assert property (@(posedge MCLK)
    disable iff (!RST_B)
    (state == ST_WR && dif.set_op) |-> MEM_WDATA[dif.bit_idx])
    else $error("set op wrote a zero into the selected bit");
  a_clear_writes_zero: assert property (@(posedge MCLK)
    disable iff (!RST_B)
    (state == ST_WR && !dif.set_op) |-> !MEM_WDATA[dif.bit_idx])
    else $error("clear op wrote a one into the selected bit");
  a_carry_from_read: assert property (@(posedge MCLK)
    disable iff (!RST_B)
    (state == ST_RD && MEM_ACK && CLK_EN) |=>
      CARRY == $past(MEM_RDATA[dif.bit_idx]) && state == ST_WR)
    else $error("carry not loaded from the read before the write");
  a_flags_kept: assert property (@(posedge MCLK)
    disable iff (!RST_B)
    (state == ST_RD && MEM_ACK && CLK_EN) |=>
      psw[15:1] == $past(psw[15:1]))
    else $error("memory destination disturbed other status bits");
  a_psw_only_sel: assert property (@(posedge MCLK)
    disable iff (!RST_B)
    (state == ST_REG && is_psw && CLK_EN) |=>
      ((psw ^ $past(psw)) & ~$past(sel_mask)) == 16'h0000)
    else $error("status word changed outside the selected bit");
  a_psw_sel_bit: assert property (@(posedge MCLK)
    disable iff (!RST_B)
    (state == ST_REG && is_psw && CLK_EN && (sel_mask &
      `BTCS_PSW_MASK) != 16'h0000) |=>
      (psw & $past(sel_mask)) == ($past(dif.set_op) ? $past(sel_mask) :
      16'h0000))
    else $error("selected status word bit not forced");
  a_index_range: assert property (@(posedge MCLK)
    disable iff (!RST_B)
    (state == ST_ADDR && CLK_EN && dif.bit_idx > `BTCS_BIT_MAX) |=>
      illegal && !BUSY && !MEM_REQ)
    else $error("bit index above 23 was executed");
  a_min_cycles: assert property (@(posedge MCLK)
    disable iff (!RST_B)
    ($fell(BUSY) && !illegal) |-> hcnt >= 3'h4)
    else $error("instruction finished in fewer than four cycles");
  a_io_high_addr: assert property (@(posedge MCLK)
    disable iff (!RST_B)
    (state == ST_ADDR && CLK_EN && dif.legal && dif.form == FORM_IO) |=>
      MEM_ADDR[MEM_AW-1:6] == '1)
    else $error("I/O short address not one-extended");
endmodule // btcs_exec

//--- shared/btcs_consts.svh
`ifndef BTCS_CONSTS_SVH
`define BTCS_CONSTS_SVH
`define BTCS_OFF_OPCODE 8'h00
`define BTCS_OFF_EXT 8'h04
`define BTCS_OFF_STATUS 8'h08
`define BTCS_OFF_PSW 8'h0C
`define BTCS_OFF_REGSEL 8'h10
`define BTCS_OFF_REGDAT 8'h14
`define BTCS_UPPER_BYTE 8'h0A
`define BTCS_BIT_MAX 5'h17
`define BTCS_BASE_CYC 3'h4
`define BTCS_PSW_CODE 6'h39
`define BTCS_PSW_MASK 16'hAF7F
`define BTCS_PSW_RST 16'h0000
`define BTCS_ABS_EA 6'h30
`define BTCS_F_SPACE 6
`define BTCS_F_SETSEL 5
`define BTCS_F_ZERO7 7
`define BTCS_ST_BUSY 0
`define BTCS_ST_ILL 1
`define BTCS_ST_CARRY 2
`define BTCS_ST_EXTW 3
`define BTCS_ST_DONE 4
`endif

//--- shared/btcs_dec_if.sv
`timescale 1ns/1ps
interface btcs_dec_if;
  logic [23:0] opcode;
  logic legal;
  btcs_pkg::btcs_form_t form;
  logic [2:0] ea_mode;
  logic [2:0] ea_reg;
  logic [5:0] field6;
  logic space;
  logic set_op;
  logic [4:0] bit_idx;
  logic needs_ext;
  modport dec(input opcode, output legal, form, ea_mode, ea_reg, field6,
    space, set_op, bit_idx, needs_ext);
  modport exe(output opcode, input legal, form, ea_mode, ea_reg, field6,
    space, set_op, bit_idx, needs_ext);
endinterface

//--- shared/btcs_pkg.sv
package btcs_pkg;
  typedef enum logic [1:0] {
    FORM_ABS = 2'b00,
    FORM_EA = 2'b01,
    FORM_IO = 2'b10,
    FORM_REG = 2'b11
  } btcs_form_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_RD = 3'b010,
    ST_WR = 3'b011,
    ST_REG = 3'b100,
    ST_PAD = 3'b101
  } btcs_state_t;
  function automatic logic reg_code_ok(input logic [5:0] c);
    reg_code_ok = (c[5:2] == 4'h1) || (c[5:3] == 3'h1) ||
      (c[5:3] == 3'h2) || (c[5:3] == 3'h3) || (c[5:3] == 3'h4) ||
      (c[5:3] == 3'h7);
  endfunction
  function automatic logic [23:0] bit_apply(input logic [23:0] v,
      input logic [4:0] n, input logic set_op);
    logic [23:0] m;
    m = 24'h000001 << n;
    bit_apply = set_op ? (v | m) : (v & ~m);
  endfunction
  function automatic logic [23:0] be_merge(input logic [23:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    be_merge = old;
    for (int i = 0; i < 3; i++) begin
      if (be[i]) be_merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction
endpackage

//--- verification/btcs_mem_model.sv
`timescale 1ns/1ps
module btcs_mem_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_space,
  input wire logic mem_lock,
  input wire logic [15:0] mem_addr,
  input wire logic [23:0] mem_wdata,
  output logic [23:0] mem_rdata,
  output logic mem_ack,
  input wire logic slow,
  input wire logic other_req,
  output logic other_gnt
);
  logic [23:0] mem [0:511];
  logic [15:0] last_rd;
  logic [15:0] last_wr;
  logic [1:0] wait_n;
  int n_acc;
  int lock_gap;
  // Rival master held off while the pair is locked
  assign other_gnt = other_req && !mem_lock && !mem_req;
  // Data lines toggle outside an ack so stale data never looks valid
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      wait_n <= 2'h0;
      mem_rdata <= 24'h5A5A5A;
      n_acc <= 0;
      lock_gap <= 0;
    end else if (mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      wait_n <= 2'h0;
      mem_rdata <= ~mem_rdata;
    end else if (wait_n < (slow ? 2'h3 : 2'h0)) begin
      wait_n <= wait_n + 2'h1;
      mem_rdata <= ~mem_rdata;
    end else begin
      mem_ack <= 1'b1;
      n_acc <= n_acc + 1;
      if (!mem_lock) lock_gap <= lock_gap + 1;
      if (mem_we) begin
        mem[{mem_space, mem_addr[7:0]}] <= mem_wdata;
        last_wr <= mem_addr;
      end else begin
        mem_rdata <= mem[{mem_space, mem_addr[7:0]}];
        last_rd <= mem_addr;
      end
    end
  end
endmodule // btcs_mem_model

//--- verification/test_bit_test_clear_set_exec.sv
`timescale 1ns/1ps
`include "btcs_consts.svh"
module test_bit_test_clear_set_exec;
  logic mclk, rst_b, av_rd, av_wr, slow, wreq, m_req, m_we, m_sp, m_lock;
  logic m_ack, busy, carry, en, gnt;
  logic [7:0] av_a;
  logic [31:0] av_wd, av_q, rd;
  logic [15:0] m_addr;
  logic [23:0] m_wd, m_rd;
  logic [5:0] codes [6] = '{6'h04, 6'h08, 6'h10, 6'h18, 6'h20, 6'h38};
  logic [23:0] bad [6];
  int n_mismatch = 0, n_tests = 0, cyc = 0, bcyc, acc0;
  btcs_exec #(.MEM_AW(16)) dut (.MCLK(mclk), .RST_B(rst_b), .CLK_EN(en),
    .AVS_ADDRESS(av_a), .AVS_READ(av_rd), .AVS_WRITE(av_wr),
    .AVS_WRITEDATA(av_wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(av_q),
    .AVS_WAITREQUEST(wreq), .MEM_REQ(m_req), .MEM_WE(m_we),
    .MEM_SPACE(m_sp), .MEM_LOCK(m_lock), .MEM_ADDR(m_addr),
    .MEM_WDATA(m_wd), .MEM_RDATA(m_rd), .MEM_ACK(m_ack), .BUSY(busy),
    .CARRY(carry));
  btcs_mem_model mem_i (.mclk(mclk), .rst_b(rst_b), .mem_req(m_req),
    .mem_we(m_we), .mem_space(m_sp), .mem_lock(m_lock), .mem_addr(m_addr),
    .mem_wdata(m_wd), .mem_rdata(m_rd), .mem_ack(m_ack), .slow(slow),
    .other_req(1'b1), .other_gnt(gnt));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Whole run is well under this; a hang lands here
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task chk_n(input int got, input int lo, input int hi, input string m);
    n_tests++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("wrong value at %0t: %s count %0d", $time, m, got);
    end
  endtask
  // Request held until waitrequest is sampled low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    av_a <= a;
    av_wd <= d;
    av_rd <= !w;
    av_wr <= w;
    @(posedge mclk);
    while (wreq !== 1'b0) @(posedge mclk);
    rd = av_q;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask
  task reg_io(input logic w, input logic [5:0] c, input logic [23:0] v);
    bus(1'b1, `BTCS_OFF_REGSEL, {26'h0, c});
    bus(w, `BTCS_OFF_REGDAT, {8'h00, v});
  endtask
  // Start an instruction, count busy cycles, then fetch status
  task run(input logic [23:0] op);
    bus(1'b1, `BTCS_OFF_OPCODE, {8'h00, op});
    bcyc = 0;
    @(posedge mclk);
    while (busy === 1'b1) begin
      bcyc++;
      @(posedge mclk);
    end
    bus(1'b0, `BTCS_OFF_STATUS, 32'h0);
  endtask
  function automatic logic [23:0] opc(input logic [1:0] f,
      input logic [5:0] c, input logic s, input logic st, input logic [4:0] n);
    opc = {`BTCS_UPPER_BYTE, f, c, 1'b0, s, st, n};
  endfunction
  task mem_op(input logic [23:0] op, input logic [15:0] ext, input logic sp,
      input logic [15:0] a, input logic [23:0] pre, input logic [23:0] post,
      input logic [31:0] st, input logic sl);
    mem_i.mem[{sp, a[7:0]}] = pre;
    slow <= sl;
    acc0 = mem_i.n_acc;
    bus(1'b1, `BTCS_OFF_EXT, {16'h0, ext});
    run(op);
    chk(rd, st, "memory status");
    chk({8'h00, mem_i.mem[{sp, a[7:0]}]}, {8'h00, post}, "memory");
    chk({16'h0, mem_i.last_rd}, {16'h0, a}, "read address");
    chk({16'h0, mem_i.last_wr}, {16'h0, a}, "write address");
    chk_n(mem_i.n_acc - acc0, 2, 2, "accesses");
    chk_n(mem_i.lock_gap, 0, 0, "unlocked access");
    chk({31'h0, gnt}, 32'h1, "rival granted");
    chk_n(bcyc, 4, 40, "memory busy");
  endtask
  initial begin
    rst_b = 1'b0;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_a = 8'h00;
    av_wd = 32'h0;
    slow = 1'b0;
    en = 1'b1;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    bus(1'b0, `BTCS_OFF_STATUS, 32'h0);
    chk(rd, 32'h0, "status at reset");
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    bus(1'b1, `BTCS_OFF_PSW, 32'hAF7E);
    $display("test reset done");
    foreach (codes[i]) begin
      reg_io(1'b1, codes[i], 24'h00A5A5);
      run(opc(2'b11, codes[i], 1'b1, 1'b1, 5'h01));
      chk(rd, 32'h10, "set status");
      chk_n(bcyc, 4, 4, "register busy");
      reg_io(1'b0, codes[i], 24'h0);
      chk(rd, 32'h00A5A7, "set value");
      run(opc(2'b11, codes[i], 1'b1, 1'b0, 5'h00));
      chk({31'h0, carry}, 32'h1, "carry");
      reg_io(1'b0, codes[i], 24'h0);
      chk(rd, 32'h00A5A6, "clear value");
    end
    reg_io(1'b1, 6'h08, 24'h800000);
    run(opc(2'b11, 6'h08, 1'b1, 1'b0, 5'h17));
    chk(rd, 32'h14, "top bit status");
    bus(1'b0, `BTCS_OFF_PSW, 32'h0);
    chk(rd, 32'hAF7F, "other flags");
    reg_io(1'b1, 6'h04, 24'h0);
    bus(1'b1, `BTCS_OFF_OPCODE,
      {8'h00, opc(2'b11, 6'h04, 1'b1, 1'b1, 5'h03)});
    en <= 1'b0;
    repeat (6) @(posedge mclk);
    chk({31'h0, busy}, 32'h1, "frozen busy");
    en <= 1'b1;
    while (busy === 1'b1) @(posedge mclk);
    reg_io(1'b0, 6'h04, 24'h0);
    chk(rd, 32'h08, "frozen set value");
    $display("test register forms done");
    bus(1'b1, `BTCS_OFF_PSW, 32'h0001);
    run(opc(2'b11, `BTCS_PSW_CODE, 1'b1, 1'b1, 5'h08));
    bus(1'b0, `BTCS_OFF_PSW, 32'h0);
    chk(rd, 32'h0101, "mode bit");
    run(opc(2'b11, `BTCS_PSW_CODE, 1'b1, 1'b0, 5'h00));
    run(opc(2'b11, `BTCS_PSW_CODE, 1'b1, 1'b1, 5'h06));
    bus(1'b0, `BTCS_OFF_PSW, 32'h0);
    chk(rd, 32'h0140, "flag bits");
    run(opc(2'b11, `BTCS_PSW_CODE, 1'b1, 1'b1, 5'h0F));
    run(opc(2'b11, `BTCS_PSW_CODE, 1'b1, 1'b1, 5'h14));
    bus(1'b0, `BTCS_OFF_PSW, 32'h0);
    chk(rd, 32'h8140, "top mode bit");
    reg_io(1'b0, `BTCS_PSW_CODE, 24'h0);
    chk(rd, 32'h8140, "status word alias");
    $display("test status word done");
    mem_op(opc(2'b00, 6'h05, 1'b0, 1'b1, 5'h00), 16'h0, 1'b0, 16'h0005,
      24'h0, 24'h000001, 32'h10, 1'b0);
    mem_op(opc(2'b10, 6'h3F, 1'b1, 1'b0, 5'h0E), 16'h0, 1'b1, 16'hFFFF,
      24'hFFFFFF, 24'hFFBFFF, 32'h14, 1'b1);
    mem_op(opc(2'b01, 6'h30, 1'b1, 1'b1, 5'h17), 16'h0123, 1'b1, 16'h0123,
      24'h0, 24'h800000, 32'h18, 1'b0);
    reg_io(1'b1, 6'h12, 24'h000040);
    mem_op(opc(2'b01, 6'h22, 1'b0, 1'b0, 5'h05), 16'h0, 1'b0, 16'h0040,
      24'h000020, 24'h0, 32'h14, 1'b1);
    reg_io(1'b0, 6'h12, 24'h0);
    chk(rd, 32'h40, "no update");
    mem_op(opc(2'b01, 6'h1A, 1'b0, 1'b1, 5'h02), 16'h0, 1'b0, 16'h0040,
      24'h0, 24'h000004, 32'h10, 1'b0);
    reg_io(1'b0, 6'h12, 24'h0);
    chk(rd, 32'h41, "post increment");
    reg_io(1'b1, 6'h1A, 24'h000003);
    mem_op(opc(2'b01, 6'h02, 1'b0, 1'b1, 5'h00), 16'h0, 1'b0, 16'h0041,
      24'h0, 24'h000001, 32'h10, 1'b0);
    mem_op(opc(2'b01, 6'h2A, 1'b0, 1'b1, 5'h00), 16'h0, 1'b0, 16'h0041,
      24'h0, 24'h000001, 32'h10, 1'b1);
    mem_op(opc(2'b01, 6'h3A, 1'b0, 1'b1, 5'h00), 16'h0, 1'b0, 16'h003D,
      24'h0, 24'h000001, 32'h10, 1'b0);
    mem_op(opc(2'b01, 6'h0A, 1'b1, 1'b0, 5'h01), 16'h0, 1'b1, 16'h003D,
      24'h000002, 24'h0, 32'h14, 1'b0);
    mem_op(opc(2'b01, 6'h12, 1'b0, 1'b1, 5'h00), 16'h0, 1'b0, 16'h0040,
      24'h0, 24'h000001, 32'h10, 1'b0);
    reg_io(1'b0, 6'h12, 24'h0);
    chk(rd, 32'h3F, "offset modes");
    $display("test memory forms done");
    bad[0] = opc(2'b11, 6'h08, 1'b1, 1'b1, 5'h18);
    bad[1] = opc(2'b00, 6'h05, 1'b0, 1'b1, 5'h00) ^ 24'h010000;
    bad[2] = opc(2'b00, 6'h05, 1'b0, 1'b1, 5'h00) | 24'h000080;
    bad[3] = opc(2'b11, 6'h08, 1'b0, 1'b1, 5'h00);
    bad[4] = opc(2'b11, 6'h00, 1'b1, 1'b1, 5'h00);
    bad[5] = opc(2'b01, 6'h31, 1'b0, 1'b1, 5'h00);
    foreach (bad[i]) begin
      acc0 = mem_i.n_acc;
      run(bad[i]);
      chk(rd & 32'h2, 32'h2, "refused");
      chk_n(mem_i.n_acc - acc0, 0, 0, "refused access");
    end
    reg_io(1'b0, 6'h08, 24'h0);
    chk(rd, 32'h0, "refused target");
    $display("test refused opcodes done");
    give_verdict();
  end
endmodule // test_bit_test_clear_set_exec
